// >>> design/mid_pkg.sv
// Purpose: Shared constants and types for the instruction decoder block
// Assumes: 16-bit instruction words, AHB-Lite register access, 32-bit bus data
// Notes:   Cycle figures are held in quarter cycles so shift timing stays exact
package mid_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  localparam logic        HRESP_OKAY    = 1'b0;

  // Register byte offsets
  localparam logic [7:0] REG_INSTR  = 8'h00;
  localparam logic [7:0] REG_OPWORD = 8'h04;
  localparam logic [7:0] REG_PREG   = 8'h08;
  localparam logic [7:0] REG_XREG   = 8'h0c;
  localparam logic [7:0] REG_BREG   = 8'h10;
  localparam logic [7:0] REG_AREG   = 8'h14;
  localparam logic [7:0] REG_FLAGS  = 8'h18;
  localparam logic [7:0] REG_CLASS  = 8'h1c;
  localparam logic [7:0] REG_EADDR  = 8'h20;
  localparam logic [7:0] REG_FIELDS = 8'h24;
  localparam logic [7:0] REG_TIMING = 8'h28;
  localparam logic [7:0] REG_RESULT = 8'h2c;

  // Primary opcodes
  localparam logic [3:0] OPC_GENERIC          = 4'h0;
  localparam logic [3:0] OPC_IO               = 4'h8;
  localparam logic [3:0] INCREMENT_REPLACE_OP = 4'h4;
  localparam logic [3:0] OPC_MUL              = 4'he;
  localparam logic [3:0] OPC_DIV              = 4'hf;

  // Mode field of the generic opcode
  localparam logic [2:0] MODE_HALT   = 3'h0;
  localparam logic [2:0] MODE_JUMP   = 3'h1;
  localparam logic [2:0] MODE_JMARK  = 3'h2;
  localparam logic [2:0] MODE_EXEC   = 3'h3;
  localparam logic [2:0] MODE_SHIFT  = 3'h4;
  localparam logic [2:0] MODE_REGCHG = 3'h5;
  localparam logic [2:0] MODE_IMMED  = 3'h6;
  localparam logic [2:0] MODE_OVF    = 3'h7;

  // Address modes of memory-reference words
  localparam logic [2:0] AM_REL   = 3'h4;
  localparam logic [2:0] AM_IDX_X = 3'h5;
  localparam logic [2:0] AM_IDX_B = 3'h6;
  localparam logic [2:0] AM_IND   = 3'h7;
  localparam logic [2:0] EXT_IMMEDIATE = 3'h0;
  localparam logic [2:0] EXT_INDIRECT  = 3'h7;

  // Address-field codes
  localparam logic [8:0] AF_NOP       = 9'h000;
  localparam logic [8:0] CLEAR_OVF_OP = 9'h100;
  localparam logic [8:0] AF_SET_OVF   = 9'h101;

  // Register-change kinds
  localparam logic [1:0] RC_KEEP = 2'h0;
  localparam logic [1:0] RC_INC  = 2'h1;
  localparam logic [1:0] RC_CPL  = 2'h2;
  localparam logic [1:0] RC_DEC  = 2'h3;

  // Input/output modes and functions
  localparam logic [2:0] EXTERNAL_CONTROL_OP  = 3'h0;
  localparam logic [2:0] PROGRAM_SENSE_OP     = 3'h1;
  localparam logic [2:0] IO_INPUT             = 3'h2;
  localparam logic [2:0] IO_OUTPUT            = 3'h3;
  localparam logic [2:0] IO_FUNC_MEM          = 3'h0;
  localparam logic [2:0] OR_INPUT_BOTH_ACC    = 3'h3;
  localparam logic [2:0] IO_FUNC_RSVD         = 3'h4;
  localparam logic [2:0] CLEAR_INPUT_BOTH_ACC = 3'h7;

  // Timing in quarter cycles
  localparam logic [7:0] Q_ONE         = 8'h04;
  localparam logic [7:0] Q_TWO         = 8'h08;
  localparam logic [7:0] Q_THREE       = 8'h0c;
  localparam logic [7:0] Q_MUL         = 8'h28;
  localparam logic [7:0] Q_DIV_MAX     = 8'h38;
  localparam logic [7:0] Q_EXT_MUL     = 8'h2c;
  localparam logic [7:0] Q_EXT_DIV_MAX = 8'h3c;
  localparam logic [7:0] Q_SHIFT_ONE   = 8'h01;
  localparam logic [7:0] Q_SHIFT_TWO   = 8'h02;

  // Program counter steps
  localparam logic [15:0] WORD_STEP   = 16'h0001;
  localparam logic [15:0] MARK_RETURN = 16'h0002;

  typedef enum logic [3:0] {
    GRP_NONE    = 4'h0,
    GRP_MEMREF  = 4'h1,
    GRP_NONADDR = 4'h2,
    GRP_SHIFT   = 4'h3,
    GRP_REGCHG  = 4'h4,
    GRP_JUMP    = 4'h5,
    GRP_JMARK   = 4'h6,
    GRP_EXEC    = 4'h7,
    GRP_IMMED   = 4'h8,
    GRP_IO      = 4'h9,
    GRP_EXTEND  = 4'ha,
    GRP_INVALID = 4'hb
  } mid_group_e;

  typedef struct packed {
    logic [3:0] opc;
    logic [2:0] mode;
    logic [8:0] afield;
  } mid_word_s;

  typedef struct packed {
    logic       long_pair;
    logic       acc_high;
    logic       right;
    logic       logical;
    logic [4:0] count;
  } mid_shift_s;

  typedef struct packed {
    logic       cond;
    logic [1:0] kind;
    logic       src_x;
    logic       src_b;
    logic       src_a;
    logic       dst_x;
    logic       dst_b;
    logic       dst_a;
  } mid_rc_s;

  typedef struct packed {
    logic [2:0] func;
    logic [5:0] dev;
  } mid_io_s;

  typedef struct packed {
    logic [1:0] hi;
    logic [3:0] subop;
    logic [2:0] xmode;
  } mid_imm_s;

  typedef struct packed {
    logic sense_switch_three;
    logic sense_switch_two;
    logic sense_switch_one;
    logic overflow_flag;
  } mid_flags_s;

  typedef struct packed {
    mid_group_e  grp;
    logic [15:0] ea;
    logic        indirect;
    logic        cond_met;
    logic        wr_en;
    logic        halt;
    logic        ovf_clr;
    logic        ovf_set;
    logic        shift_ok;
    logic [3:0]  subop;
    logic [2:0]  amode;
    logic [7:0]  tmin;
    logic [7:0]  tmax;
    logic [15:0] result;
  } mid_dec_s;

endpackage

// >>> design/mid_decoder.sv
// Purpose: Decodes 16-bit accumulator-machine instruction words for the sequencer
// Assumes: Single 50 MHz clock, AHB-Lite single word transfers, zero wait states
// Notes:   Software loads the word and machine state, then reads class, address,
//          fields and timing; all reads reflect writes completed the cycle before
//
// Behaviour
// - Bit 11 clear gives direct address: bits 10-9 above the nine-bit field.
// - Modes 100, 101, 110 add field to program counter, index, low accumulator.
// - Mode 111 treats the field as location of the operand address word.
// - Memory words take 2 cycles; increment-replace 3, multiply 10, divide 10-14.
// - Halt on mode 0; mode 5 field 0 no-op; mode 7 clears/sets overflow; 1 cycle.
// - Shift fields: pair, high accumulator, right, logical rotate, five-bit count.
// - Single shift 1 + 0.25 per place; double shift 1 + 0.50 per place.
// - Register change: bits 5-3 sources, 2-0 destinations, 7-6 kind, one cycle.
// - Several sources transfer their OR; complement kind transfers its complement.
// - Bit 8 set makes register change take effect only while overflow is on.
// - Conditional increment adds overflow, conditional decrement subtracts it.
// - Jump taken only when all flagged conditions hold; takes 2 cycles.
// - Jump-and-mark: 2 cycles failed, 3 taken; unconditional form always 3.
// - Execute applies the same conditions; target must be a one-word instruction.
// - Immediate codes take operand from next word; memory-form timing.
// - Input/output: low digits device, upper digit mode; control 1, sense 2.
// - Combined OR input takes 2 cycles; input to memory takes 3.
// - Clear-and-input codes zero the selected accumulators first; 2 cycles.
// - Output from memory 3 cycles; from accumulators or their OR 2 cycles.
// - Extended codes take second word as address; 3, multiply 11, divide 11-15.
`timescale 1ns/1ps

module mid_decoder (
  // Clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // Sequencer side
  output logic                             decode_done,
  output logic                             shift_start,
  output logic                             halt_op,
  output mid_pkg::mid_group_e              group
);
  import mid_pkg::*;

  typedef struct packed {
    logic [15:0] instr;
    logic [15:0] opword;
    logic [15:0] preg;
    logic [15:0] xreg;
    logic [15:0] breg;
    logic [15:0] areg;
    mid_flags_s  flags;
    logic        wr_pend;
    logic [7:0]  waddr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        decode_done;
    logic        shift_start;
    mid_dec_s    dec;
  } mid_state_s;

  mid_state_s s;
  mid_state_s next_s;
  mid_dec_s   dec;
  logic       take;

  // Memory-form timing shared by memory, immediate and extended groups
  function automatic logic [15:0] mid_mem_time(input logic [3:0] opc, input logic ext);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = ext ? Q_THREE : Q_TWO;
    if (opc == INCREMENT_REPLACE_OP && !ext) begin
      lo = Q_THREE;
    end else if (opc == OPC_MUL) begin
      lo = ext ? Q_EXT_MUL : Q_MUL;
    end else if (opc == OPC_DIV) begin
      lo = ext ? Q_EXT_MUL : Q_MUL;
    end
    hi = lo;
    if (opc == OPC_DIV) begin
      hi = ext ? Q_EXT_DIV_MAX : Q_DIV_MAX;
    end
    return {hi, lo};
  endfunction

  // Effective address of a single-word memory reference
  function automatic logic [16:0] mid_eaddr(input logic [2:0] mode, input logic [8:0] af,
                                            input logic [15:0] p, input logic [15:0] x,
                                            input logic [15:0] b);
    logic [15:0] ea;
    logic        ind;
    ind = 1'b0;
    case (mode)
      AM_REL:   ea = p + 16'(af);
      AM_IDX_X: ea = x + 16'(af);
      AM_IDX_B: ea = b + 16'(af);
      AM_IND: begin
        ea  = 16'(af);
        ind = 1'b1;
      end
      default:  ea = 16'({mode, af});
    endcase
    return {ind, ea};
  endfunction

  // Whole-word decode against the machine state held in the registers
  function automatic mid_dec_s mid_decode(input logic [15:0] w, input logic [15:0] ow,
                                          input logic [15:0] p, input logic [15:0] x,
                                          input logic [15:0] b, input logic [15:0] a,
                                          input mid_flags_s f);
    mid_dec_s    d;
    mid_word_s   iw;
    mid_shift_s  sh;
    mid_rc_s     rc;
    mid_io_s     io;
    mid_imm_s    im;
    logic [8:0]  cv;
    logic [15:0] srcv;
    logic [15:0] tm;
    logic [16:0] ev;
    d    = '0;
    iw   = w;
    sh   = iw.afield;
    rc   = iw.afield;
    io   = iw.afield;
    im   = iw.afield;
    d.subop = iw.opc;
    d.amode = iw.mode;
    // Condition vector in field order, all flagged terms must hold
    cv = {f.sense_switch_three, f.sense_switch_two, f.sense_switch_one,
          x == '0, b == '0, a == '0, $signed(a) < 0, $signed(a) >= 0, f.overflow_flag};
    d.cond_met = &(~iw.afield | cv);
    // Register-change source merge
    srcv = (rc.src_x ? x : '0) | (rc.src_b ? b : '0) | (rc.src_a ? a : '0);
    case (iw.opc)
      OPC_GENERIC: begin
        case (iw.mode)
          MODE_HALT: begin
            d.grp  = GRP_NONADDR;
            d.halt = 1'b1;
            d.tmin = Q_ONE;
            d.tmax = Q_ONE;
          end
          MODE_JUMP, MODE_EXEC: begin
            d.grp  = (iw.mode == MODE_JUMP) ? GRP_JUMP : GRP_EXEC;
            d.ea   = ow;
            d.tmin = Q_TWO;
            d.tmax = Q_TWO;
          end
          MODE_JMARK: begin
            d.grp    = GRP_JMARK;
            d.ea     = ow;
            d.result = p + MARK_RETURN;
            d.wr_en  = d.cond_met;
            d.tmin   = (iw.afield == AF_NOP || d.cond_met) ? Q_THREE : Q_TWO;
            d.tmax   = d.tmin;
          end
          MODE_SHIFT: begin
            d.shift_ok = !(sh.long_pair && sh.acc_high);
            d.grp      = d.shift_ok ? GRP_SHIFT : GRP_INVALID;
            d.tmin     = Q_ONE + 8'(sh.count) *
                         (sh.long_pair ? Q_SHIFT_TWO : Q_SHIFT_ONE);
            d.tmax     = d.tmin;
          end
          MODE_REGCHG: begin
            d.grp   = (iw.afield == AF_NOP) ? GRP_NONADDR : GRP_REGCHG;
            d.wr_en = !rc.cond || f.overflow_flag;
            d.tmin  = Q_ONE;
            d.tmax  = Q_ONE;
            case (rc.kind)
              RC_INC:  d.result = rc.cond ? srcv + 16'(f.overflow_flag)
                                          : srcv + WORD_STEP;
              RC_CPL:  d.result = ~srcv;
              RC_DEC:  d.result = rc.cond ? srcv - 16'(f.overflow_flag)
                                          : srcv - WORD_STEP;
              default: d.result = srcv;
            endcase
          end
          MODE_IMMED: begin
            d.subop = im.subop;
            d.amode = im.xmode;
            tm      = mid_mem_time(im.subop, im.xmode != EXT_IMMEDIATE);
            d.tmin  = tm[7:0];
            d.tmax  = tm[15:8];
            if (im.hi != '0 || im.subop == OPC_GENERIC || im.subop == OPC_IO) begin
              d.grp = GRP_INVALID;
            end else if (im.xmode == EXT_IMMEDIATE) begin
              d.grp = GRP_IMMED;
              d.ea  = p + WORD_STEP;
            end else begin
              d.grp      = GRP_EXTEND;
              d.ea       = ow;
              d.indirect = (im.xmode == EXT_INDIRECT);
            end
          end
          default: begin
            d.ovf_clr = (iw.afield == CLEAR_OVF_OP);
            d.ovf_set = (iw.afield == AF_SET_OVF);
            d.grp     = (d.ovf_clr || d.ovf_set) ? GRP_NONADDR : GRP_INVALID;
            d.tmin    = Q_ONE;
            d.tmax    = Q_ONE;
          end
        endcase
      end
      OPC_IO: begin
        d.grp = GRP_IO;
        d.ea  = 16'(io.dev);
        case (iw.mode)
          EXTERNAL_CONTROL_OP: d.tmin = Q_ONE;
          PROGRAM_SENSE_OP:    d.tmin = Q_TWO;
          IO_INPUT: begin
            if (io.func == IO_FUNC_RSVD) begin
              d.grp = GRP_INVALID;
            end
            d.tmin = (io.func == IO_FUNC_MEM) ? Q_THREE : Q_TWO;
            d.ovf_clr = 1'b0;
          end
          IO_OUTPUT: begin
            if (io.func > OR_INPUT_BOTH_ACC) begin
              d.grp = GRP_INVALID;
            end
            d.tmin = (io.func == IO_FUNC_MEM) ? Q_THREE : Q_TWO;
          end
          default: d.grp = GRP_INVALID;
        endcase
        d.tmax = d.tmin;
      end
      default: begin
        d.grp      = GRP_MEMREF;
        ev         = mid_eaddr(iw.mode, iw.afield, p, x, b);
        d.ea       = ev[15:0];
        d.indirect = ev[16];
        tm         = mid_mem_time(iw.opc, 1'b0);
        d.tmin     = tm[7:0];
        d.tmax     = tm[15:8];
      end
    endcase
    return d;
  endfunction

  // Address phase seen only when the bus is ready and a real transfer is offered
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // Next-state: data-phase write, decode on the updated word, read forwarding
  always_comb begin
    next_s             = s;
    next_s.decode_done = 1'b0;
    next_s.shift_start = 1'b0;
    next_s.hreadyout   = 1'b1;
    next_s.hresp       = HRESP_OKAY;
    if (s.wr_pend) begin
      case (s.waddr)
        REG_INSTR: begin
          next_s.instr       = hwdata[WORD_W-1:0];
          next_s.decode_done = 1'b1;
        end
        REG_OPWORD: next_s.opword = hwdata[WORD_W-1:0];
        REG_PREG:   next_s.preg   = hwdata[WORD_W-1:0];
        REG_XREG:   next_s.xreg   = hwdata[WORD_W-1:0];
        REG_BREG:   next_s.breg   = hwdata[WORD_W-1:0];
        REG_AREG:   next_s.areg   = hwdata[WORD_W-1:0];
        REG_FLAGS:  next_s.flags  = hwdata[$bits(mid_flags_s)-1:0];
        default:    next_s.flags  = next_s.flags;                  // Read-only or unmapped
      endcase
    end
    next_s.wr_pend = take && hwrite;
    next_s.waddr   = haddr[ADDR_W-1:0];
    // Decoding the forwarded word lets a read follow a write back to back
    dec          = mid_decode(next_s.instr, next_s.opword, next_s.preg, next_s.xreg,
                              next_s.breg, next_s.areg, next_s.flags);
    next_s.dec   = dec;
    next_s.shift_start = next_s.decode_done && dec.shift_ok;
    if (take && !hwrite) begin
      case (haddr[ADDR_W-1:0])
        REG_INSTR:  next_s.hrdata = 32'(next_s.instr);
        REG_OPWORD: next_s.hrdata = 32'(next_s.opword);
        REG_PREG:   next_s.hrdata = 32'(next_s.preg);
        REG_XREG:   next_s.hrdata = 32'(next_s.xreg);
        REG_BREG:   next_s.hrdata = 32'(next_s.breg);
        REG_AREG:   next_s.hrdata = 32'(next_s.areg);
        REG_FLAGS:  next_s.hrdata = 32'(next_s.flags);
        REG_CLASS:  next_s.hrdata = 32'({dec.grp, dec.indirect, dec.cond_met, dec.wr_en,
                                         dec.halt, dec.ovf_clr, dec.ovf_set, dec.shift_ok});
        REG_EADDR:  next_s.hrdata = 32'(dec.ea);
        REG_FIELDS: next_s.hrdata = 32'({dec.subop, dec.amode});
        REG_TIMING: next_s.hrdata = 32'({dec.tmax, dec.tmin});
        REG_RESULT: next_s.hrdata = 32'(dec.result);
        default:    next_s.hrdata = '0;                            // Unmapped reads zero
      endcase
    end
  end

  // State register; ready stays high so the bus is never stalled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s           <= '0;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign hrdata      = s.hrdata;
  assign hreadyout   = s.hreadyout;
  assign hresp       = s.hresp;
  assign decode_done = s.decode_done;
  assign shift_start = s.shift_start;
  assign halt_op     = s.dec.halt;
  assign group       = s.dec.grp;

  // Checks on the registered decode against the word that caused it
  mid_word_s  chk_w;
  mid_shift_s chk_sh;
  mid_rc_s    chk_rc;
  assign chk_w  = s.instr;
  assign chk_sh = chk_w.afield;
  assign chk_rc = chk_w.afield;

  default clocking chk_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_DIRECT_EA: assert property (
    (chk_w.opc != OPC_GENERIC && chk_w.opc != OPC_IO && chk_w.mode < AM_REL)
      |-> (s.dec.ea == 16'({chk_w.mode, chk_w.afield}) && !s.dec.indirect))
    else $error("direct address not formed from mode and field");
  AST_RELATIVE_EA: assert property (
    (chk_w.opc != OPC_GENERIC && chk_w.opc != OPC_IO && chk_w.mode == AM_REL)
      |-> s.dec.ea == s.preg + 16'(chk_w.afield))
    else $error("relative address not program counter plus field");
  AST_INDIRECT: assert property (
    (chk_w.opc != OPC_GENERIC && chk_w.opc != OPC_IO && chk_w.mode == AM_IND)
      |-> (s.dec.indirect && s.dec.ea == 16'(chk_w.afield)))
    else $error("indirect word not flagged");
  AST_DIVIDE_TIME: assert property (
    (chk_w.opc == OPC_DIV) |-> (s.dec.tmin == Q_MUL && s.dec.tmax == Q_DIV_MAX))
    else $error("divide timing wrong");
  // Reset word decode lands only one edge after release
  AST_HALT: assert property (
    ($past(hresetn) && chk_w.opc == OPC_GENERIC && chk_w.mode == MODE_HALT)
      |-> (halt_op && s.dec.tmin == Q_ONE))
    else $error("halt not decoded in one cycle");
  AST_SHIFT_TIME: assert property (
    (s.dec.grp == GRP_SHIFT && chk_sh.long_pair)
      |-> s.dec.tmin == Q_ONE + 8'(chk_sh.count) * Q_SHIFT_TWO)
    else $error("double shift timing wrong");
  AST_SHIFT_GATE: assert property (
    shift_start |-> (decode_done && s.dec.shift_ok && s.dec.grp == GRP_SHIFT))
    else $error("shifter started for undefined shift");
  AST_COND_CHANGE: assert property (
    (s.dec.grp == GRP_REGCHG && chk_rc.cond && !s.flags.overflow_flag) |-> !s.dec.wr_en)
    else $error("conditional register change enabled without overflow");
  AST_MARK_TIME: assert property (
    (s.dec.grp == GRP_JMARK) |-> (s.dec.tmin == ((chk_w.afield == AF_NOP || s.dec.cond_met)
                                                 ? Q_THREE : Q_TWO)))
    else $error("jump-and-mark timing wrong");
  AST_DECODE_FOLLOWS: assert property (
    (s.wr_pend && s.waddr == REG_INSTR) |=> (decode_done && s.instr == $past(hwdata[15:0])))
    else $error("written word not decoded next cycle");

endmodule // mid_decoder

// >>> dv/mid_seq_model.sv
// Purpose: Sequencer stand-in that counts shifter starts
// Assumes: Start pulses last one clock
// Notes:   Only the start request is modelled
`timescale 1ns/1ps
module mid_seq_model (
  // Decoder side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic shift_start,
  // Bench side
  output int       starts
);
  // Shifter runs only on a start pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) starts <= 0;
    else if (shift_start) starts <= starts + 1;
  end
endmodule // mid_seq_model

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the instruction decoder
// Assumes: Single slave, so hready follows hreadyout
// Notes:   Timing is compared in quarter cycles
`timescale 1ns/1ps
module tb_top;
  import mid_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic        hready, hreadyout, hresp, decode_done, shift_start, halt_op;
  mid_group_e  group;
  int          fail_count = 0, compares = 0, starts, n_st = 0, p, x, b, a, f, v, c, k, o;
  logic [15:0] w;
  // Words with a fixed cost, and their {max,min} timing
  logic [15:0] tw[17] = '{16'h4000, 16'he000, 16'hf000, 16'h8015, 16'h8215, 16'h8415,
    16'h84d5, 16'h85d5, 16'h8615, 16'h86d5, 16'h0c08, 16'h0c20, 16'h0c70, 16'h0c78,
    16'h0c0d, 16'h0c75, 16'h0c7d};
  logic [15:0] tt[17] = '{16'h0c0c, 16'h2828, 16'h3828, 16'h0404, 16'h0808, 16'h0c0c,
    16'h0808, 16'h0808, 16'h0c0c, 16'h0808, 16'h0808, 16'h0c0c, 16'h2828, 16'h3828,
    16'h0c0c, 16'h2c2c, 16'h3c2c};
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  mid_decoder u_mid_decoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .decode_done(decode_done),
    .shift_start(shift_start), .halt_op(halt_op), .group(group));
  mid_seq_model u_mid_seq_model (.hclk(hclk), .hresetn(hresetn),
    .shift_start(shift_start), .starts(starts));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Address phase held until ready, then data phase likewise
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [15:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] ad, input string nm, input logic [31:0] e);
    xfer(1'b0, ad, 16'h0);
    chk(nm, r, e);
  endtask
  // Decode result lands at the data-phase edge, so look half a cycle later
  task automatic ins(input logic [15:0] d, input logic sh);
    xfer(1'b1, REG_INSTR, d);
    @(negedge hclk);
    chk("start", {29'h0, hresp, decode_done, shift_start},
        {29'h0, HRESP_OKAY, 1'b1, sh});
    n_st += sh;
    @(posedge hclk);
  endtask
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #40us;
    fail_count++;
    summarize();
  end
  initial begin
    void'($urandom(59091));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    p = $urandom & 16'hffff;
    x = $urandom & 16'hffff;
    b = $urandom & 16'hffff;
    xfer(1'b1, REG_PREG, p[15:0]);
    xfer(1'b1, REG_XREG, x[15:0]);
    xfer(1'b1, REG_BREG, b[15:0]);
    o = $urandom & 16'hffff;
    xfer(1'b1, REG_OPWORD, o[15:0]);
    for (k = 0; k < 8; k++) begin
      v = $urandom % 512;
      ins({4'h1, k[2:0], v[8:0]}, 1'b0);
      c = k < 4 ? k * 512 + v : k == 4 ? p + v : k == 5 ? x + v : k == 6 ? b + v : v;
      rd(REG_EADDR, "eaddr", c & 32'hffff);
      xfer(1'b0, REG_CLASS, 16'h0);
      chk("indirect", {31'h0, r[6]}, k == 7);
      rd(REG_TIMING, "memtime", 32'h0808);
    end
    $display("test address done");
    for (k = 0; k < 17; k++) begin
      ins(tw[k], 1'b0);
      rd(REG_TIMING, "time", {16'h0, tt[k]});
      c = tw[k][2:0] == 3'h0 ? (p + 1) & 32'hffff : o;
      if (tw[k][15:12] == OPC_IO) rd(REG_EADDR, "dev", 32'h15);
      else if (tw[k][15:9] == 7'h06) rd(REG_EADDR, "opea", c);
    end
    $display("test timing done");
    for (k = 0; k < 16; k++) begin
      c = $urandom % 32;
      ins({7'h04, k[3:0], c[4:0]}, !(k[3] && k[2]));
      xfer(1'b0, REG_TIMING, 16'h0);
      if (!(k[3] && k[2])) chk("shift", r & 32'hff, 4 + c * (k[3] + 1));
      else chk("grp", {28'h0, group}, {28'h0, GRP_INVALID});
    end
    chk("starts", starts, n_st);
    $display("test shift done");
    for (k = 0; k < 4; k++) begin
      ins(k == 0 ? 16'h0 : k == 1 ? 16'h0a00 : 16'h0efe + k[15:0], 1'b0);
      chk("halt", {31'h0, halt_op}, k == 0);
      xfer(1'b0, REG_CLASS, 16'h0);
      chk("ovf", r & 6, (k == 2) * 4 + (k == 3) * 2);
      rd(REG_TIMING, "onecyc", 32'h0404);
    end
    $display("test control done");
    for (k = 0; k < 24; k++) begin
      a = $urandom % 3 == 0 ? 0 : $urandom & 16'hffff;
      f = $urandom % 16;
      w = 16'($urandom);
      if (k >= 12) w = w & 16'($urandom);
      w[15:9] = k < 12 ? 7'h05 : 7'(k % 3 + 1);
      w[0] = w[0] | (k < 12);
      xfer(1'b1, REG_AREG, a[15:0]);
      xfer(1'b1, REG_FLAGS, {12'h0, f[3:0]});
      ins(w, 1'b0);
      xfer(1'b0, REG_CLASS, 16'h0);
      if (k < 12) begin
        chk("wr", {31'h0, r[4]}, !w[8] || f[0]);
        v = (w[5] ? x : 0) | (w[4] ? b : 0) | (w[3] ? a : 0);
        c = w[8] ? f[0] : 1;
        v = w[7:6] == 0 ? v : w[7:6] == 1 ? v + c : w[7:6] == 2 ? ~v : v - c;
        rd(REG_RESULT, "result", v & 32'hffff);
      end else begin
        c = !(w[8] && !f[3] || w[7] && !f[2] || w[6] && !f[1] || w[5] && x != 0
          || w[4] && b != 0 || w[3] && a != 0 || w[2] && !a[15] || w[1] && a[15]
          || w[0] && !f[0]);
        chk("cond", {31'h0, r[5]}, c);
        rd(REG_EADDR, "jea", o);
        rd(REG_TIMING, "jtime", k % 3 == 1 ? 32'h0808 + c * 32'h0404 : 32'h0808);
        if (k % 3 == 1) rd(REG_RESULT, "ret", (p + 2) & 32'hffff);
      end
    end
    $display("test regchange and jump done");
    summarize();
  end
endmodule // tb_top
